/* hdl/ddc_nco_hop_select.sv */
// NCO bank with hop selection for two down-converter channels, with mixer.
// Assumes an Avalon-MM master, hop pins and sysref synchronous to clock.
//
// Notes on behaviour
// RULE_01: Four NCOs per channel, two-bit selection each.
// RULE_02: Each NCO has own frequency and phase.
// RULE_03: Accumulators always advance, selected or not.
// RULE_04: Each setting uses its own phase accumulator.
// RULE_05: Hop pin change switches the active NCO.
// RULE_06: Pin driver expects no cycle-exact switching.
// RULE_07: Pin to mixer ~45 cycles, sample ~37.
// RULE_08: Source bit one takes selection from pins.
// RULE_09: Source bit zero (reset) uses register field.
// RULE_10: Selection codes 0..3 pick NCO 0..3.
// RULE_11: Each accumulator has own tuning word.
// RULE_12: Each accumulator has own phase offset.
// RULE_13: Zero rational divider means basic mode.
// RULE_14: Accumulator adds the 32-bit word each sample.
// RULE_15: Tuning word signed or unsigned, modulo wrap.
// RULE_16: Tuning writes while running may disturb phase.
// RULE_17: Host resynchronises after changing tuning words.
// RULE_18: Hop pins pass a two-flop synchroniser.
// RULE_19: Phase offset left-justified, added to accumulator.
// RULE_20: Mixer multiplies sample by complex exponential.
// RULE_21: Armed sync plus sysref clears all accumulators.
//
// Chosen here: the Avalon-MM slave port and the register addresses.

module ddc_nco_hop_select
    import ddc_nco_pkg::*;
(
    // Clock, reset and freeze
    input  wire logic                                  clock,
    input  wire logic                                  resetn,
    input  wire logic                                  ce,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0]                     address,
    input  wire logic                                  read,
    input  wire logic                                  write,
    input  wire logic [DATA_W-1:0]                     writedata,
    input  wire logic [BE_W-1:0]                       byteenable,
    output logic      [DATA_W-1:0]                     readdata,
    output logic                                       waitrequest,
    // Hop pins and synchronisation pulse
    input  wire logic [SEL_W-1:0]                      hopPinsChanA,
    input  wire logic [SEL_W-1:0]                      hopPinsChanB,
    input  wire logic                                  sysref,
    // Sample stream in, mixed stream out
    input  wire logic [NUM_CHAN-1:0][SAMPLE_W-1:0]     adcSample,
    output iq_s       [NUM_CHAN-1:0]                   mixOut
);

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    function automatic decode_s decodeAddr(input logic [ADDR_W-1:0] a);
        decode_s d;
        d.area = AREA_NONE;
        d.chan = 1'b0;
        d.idx  = a[3:2];
        if (a[1:0] == 2'b00) begin
            if (a == CTRL_OFS) begin
                d.area = AREA_CTRL;
            end else if (a == RDIV_OFS) begin
                d.area = AREA_RDIV;
            end else if (a == STATUS_OFS) begin
                d.area = AREA_STATUS;
            end else if (a[7:4] == TW_A_OFS[7:4] || a[7:4] == TW_B_OFS[7:4]) begin
                d.area = AREA_TW;
                d.chan = (a[7:4] == TW_B_OFS[7:4]);
            end else if (a[7:4] == PH_A_OFS[7:4] || a[7:4] == PH_B_OFS[7:4]) begin
                d.area = AREA_PH;
                d.chan = (a[7:4] == PH_B_OFS[7:4]);
            end
        end
        return d;
    endfunction : decodeAddr

    function automatic logic [DATA_W-1:0] mergeBytes(input logic [DATA_W-1:0] old,
                                                     input logic [DATA_W-1:0] wd,
                                                     input logic [BE_W-1:0]   be);
        logic [DATA_W-1:0] r;
        r = old;
        for (int b = 0; b < BE_W; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return r;
    endfunction : mergeBytes

    function automatic logic signed [LUT_W-1:0] sinLut(input logic [LUT_IDX_W-1:0] idx);
        logic [4:0]              m;
        logic signed [LUT_W-1:0] mag;
        m   = idx[4] ? 5'h10 - {1'b0, idx[3:0]} : {1'b0, idx[3:0]};
        mag = SIN_QTR[m];
        return idx[5] ? -mag : mag;
    endfunction : sinLut

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [NUM_CHAN-1:0][NUM_NCO-1:0][ACC_W-1:0]   tw_q, tw_d;
    logic [NUM_CHAN-1:0][NUM_NCO-1:0][PHASE_W-1:0] ph_q, ph_d;
    logic [NUM_CHAN-1:0][NUM_NCO-1:0][ACC_W-1:0]   acc_q, acc_d;
    logic [CTRL_W-1:0]                             ctrl_q, ctrl_d;
    logic [RDIV_W-1:0]                             rdiv_q, rdiv_d;
    logic                                          armed_q, armed_d;
    logic                                          syncDone_q, syncDone_d;
    logic                                          waitrequest_q, waitrequest_d;
    logic [DATA_W-1:0]                             readdata_q, readdata_d;
    logic [NUM_CHAN-1:0][SEL_W-1:0]                hopMeta_q, hopMeta_d;
    logic [NUM_CHAN-1:0][SEL_W-1:0]                hopSync_q, hopSync_d;
    logic [NUM_CHAN-1:0][SEL_PIPE_DEPTH-1:0][SEL_W-1:0] selPipe_q, selPipe_d;
    logic [NUM_CHAN-1:0][SAMPLE_DLY-1:0][SAMPLE_W-1:0]  sampleDly_q, sampleDly_d;
    iq_s  [NUM_CHAN-1:0]                           mixOut_q, mixOut_d;

    logic [NUM_CHAN-1:0][SEL_W-1:0]                hopPins;
    logic [NUM_CHAN-1:0][SEL_W-1:0]                regSel;
    logic [NUM_CHAN-1:0][SEL_W-1:0]                selRaw;
    logic [NUM_CHAN-1:0][SEL_W-1:0]                selActive;
    logic [NUM_CHAN-1:0][SAMPLE_W-1:0]             sampleLast;
    logic [NUM_CHAN-1:0][ACC_W-1:0]                phase;
    logic                                          selectSource;
    logic                                          basicMode;
    logic                                          sysHit;
    logic                                          wrHit;
    decode_s                                       dec;
    logic [DATA_W-1:0]                             merged;
    logic [RUN_W-1:0]                              ceRun_q;

    assign hopPins      = {hopPinsChanB, hopPinsChanA};
    assign selectSource = ctrl_q[SRC_BIT];
    assign regSel       = {ctrl_q[SELB_LSB +: SEL_W], ctrl_q[SELA_LSB +: SEL_W]};
    assign basicMode    = (rdiv_q == RDIV_RST); // RULE_13
    assign sysHit       = armed_q && sysref; // RULE_21

    // ------------------------------------------------------------------
    // Register file and bus slave
    // ------------------------------------------------------------------
    // One wait state per access: the request is seen with waitrequest high,
    // the answer edge follows with waitrequest low and readdata valid.
    always_comb begin
        tw_d          = tw_q;
        ph_d          = ph_q;
        ctrl_d        = ctrl_q;
        rdiv_d        = rdiv_q;
        armed_d       = armed_q;
        syncDone_d    = syncDone_q;
        readdata_d    = readdata_q;
        waitrequest_d = !((read || write) && waitrequest_q);
        wrHit         = write && !waitrequest_q;
        dec           = decodeAddr(address);
        merged        = '0;
        if (sysHit) begin
            armed_d = 1'b0;
        end
        if (read && waitrequest_q) begin
            readdata_d = '0;
            unique case (dec.area)
                AREA_CTRL:   readdata_d = {26'h000_0000, armed_q, ctrl_q};
                AREA_RDIV:   readdata_d = {16'h0000, rdiv_q};
                AREA_STATUS: begin
                    readdata_d[ACTA_LSB +: SEL_W] = selActive[0];
                    readdata_d[ACTB_LSB +: SEL_W] = selActive[1];
                    readdata_d[ARMED_BIT]         = armed_q;
                    readdata_d[DONE_BIT]          = syncDone_q;
                    readdata_d[BASIC_BIT]         = basicMode;
                end
                AREA_TW:     readdata_d = tw_q[dec.chan][dec.idx];
                AREA_PH:     readdata_d = {16'h0000, ph_q[dec.chan][dec.idx]};
                AREA_NONE:   readdata_d = '0;
            endcase
        end
        if (wrHit) begin
            unique case (dec.area)
                AREA_CTRL: begin
                    merged = mergeBytes({26'h000_0000, armed_q, ctrl_q}, writedata, byteenable);
                    ctrl_d = merged[CTRL_W-1:0];
                    if (byteenable[0]) begin
                        armed_d = merged[ARM_BIT];
                    end
                end
                AREA_RDIV: begin
                    merged = mergeBytes({16'h0000, rdiv_q}, writedata, byteenable);
                    rdiv_d = merged[RDIV_W-1:0];
                end
                AREA_STATUS: begin
                    if (byteenable[0] && writedata[DONE_BIT]) begin
                        syncDone_d = 1'b0;
                    end
                end
                AREA_TW: begin
                    // Only the addressed word changes; a live NCO takes the new step
                    // at once, so its phase is not deterministic afterwards.
                    tw_d[dec.chan][dec.idx] = mergeBytes(tw_q[dec.chan][dec.idx],
                                                         writedata, byteenable); // RULE_02 RULE_11 RULE_16
                end
                AREA_PH: begin
                    merged = mergeBytes({16'h0000, ph_q[dec.chan][dec.idx]}, writedata, byteenable);
                    ph_d[dec.chan][dec.idx] = merged[PHASE_W-1:0]; // RULE_02 RULE_12
                end
                AREA_NONE: begin
                end
            endcase
        end
        if (sysHit) begin
            syncDone_d = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tw_q          <= '0;
            ph_q          <= '0;
            ctrl_q        <= CTRL_RST;
            rdiv_q        <= RDIV_RST;
            armed_q       <= 1'b0;
            syncDone_q    <= 1'b0;
            readdata_q    <= '0;
            waitrequest_q <= 1'b1;
        end else if (ce) begin
            tw_q          <= tw_d;
            ph_q          <= ph_d;
            ctrl_q        <= ctrl_d;
            rdiv_q        <= rdiv_d;
            armed_q       <= armed_d;
            syncDone_q    <= syncDone_d;
            readdata_q    <= readdata_d;
            waitrequest_q <= waitrequest_d;
        end
    end

    // ------------------------------------------------------------------
    // Phase accumulators
    // ------------------------------------------------------------------
    // The rational divider only shapes how software computes the word; the
    // accumulator wraps modulo 2^32 either way, so signed and unsigned words agree.
    always_comb begin
        for (int c = 0; c < NUM_CHAN; c++) begin
            for (int n = 0; n < NUM_NCO; n++) begin
                acc_d[c][n] = sysHit ? TW_RST : acc_q[c][n] + tw_q[c][n]; // RULE_03 RULE_04 RULE_14 RULE_15 RULE_21
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            acc_q <= '0;
        end else if (ce) begin
            acc_q <= acc_d;
        end
    end

    // ------------------------------------------------------------------
    // Selection path and sample delay
    // ------------------------------------------------------------------
    // The pipe lengths line the hop switch and the sample path up with the
    // mixer latencies; switching still lands anywhere within a clock of the pin.
    always_comb begin
        hopMeta_d = hopPins;
        hopSync_d = hopMeta_q; // RULE_18
        for (int c = 0; c < NUM_CHAN; c++) begin
            selRaw[c] = selectSource ? hopSync_q[c] : regSel[c]; // RULE_05 RULE_08 RULE_09
            selPipe_d[c][0] = selRaw[c];
            sampleDly_d[c][0] = adcSample[c];
            for (int k = 1; k < SEL_PIPE_DEPTH; k++) begin
                selPipe_d[c][k] = selPipe_q[c][k-1]; // RULE_07
            end
            for (int k = 1; k < SAMPLE_DLY; k++) begin
                sampleDly_d[c][k] = sampleDly_q[c][k-1]; // RULE_07
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            hopMeta_q   <= '0;
            hopSync_q   <= '0;
            selPipe_q   <= '0;
            sampleDly_q <= '0;
        end else if (ce) begin
            hopMeta_q   <= hopMeta_d;
            hopSync_q   <= hopSync_d;
            selPipe_q   <= selPipe_d;
            sampleDly_q <= sampleDly_d;
        end
    end

    // ------------------------------------------------------------------
    // Complex mixer
    // ------------------------------------------------------------------
    always_comb begin
        for (int c = 0; c < NUM_CHAN; c++) begin
            selActive[c]  = selPipe_q[c][SEL_PIPE_DEPTH-1];
            sampleLast[c] = sampleDly_q[c][SAMPLE_DLY-1];
            phase[c]      = acc_q[c][selActive[c]]
                          + {ph_q[c][selActive[c]], 16'h0000}; // RULE_01 RULE_10 RULE_19
            mixOut_d[c].i = $signed(sampleLast[c])
                          * sinLut(phase[c][ACC_W-1 -: LUT_IDX_W] + 6'h10); // RULE_20
            mixOut_d[c].q = -($signed(sampleLast[c])
                          * sinLut(phase[c][ACC_W-1 -: LUT_IDX_W])); // RULE_20
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            mixOut_q <= '0;
        end else if (ce) begin
            mixOut_q <= mixOut_d;
        end
    end

    assign mixOut      = mixOut_q;
    assign readdata    = readdata_q;
    assign waitrequest = waitrequest_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // Counts consecutive enabled cycles since reset, saturating.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ceRun_q <= '0;
        end else if (!ce) begin
            ceRun_q <= '0;
        end else if (ceRun_q != 6'h3F) begin
            ceRun_q <= ceRun_q + 6'h01;
        end
    end

    AST_BUS_ACK: assert property (@(posedge clock) disable iff (!resetn)
        (ce && (read || write) && waitrequest_q) |=> !waitrequest_q)
        else $error("Access not answered after one wait state.");

    AST_SYNC_DONE: assert property (@(posedge clock) disable iff (!resetn) // RULE_21
        (ce && sysHit) |=> (acc_q == '0) && syncDone_q)
        else $error("Armed sysref did not clear the accumulators.");

    AST_FROZEN: assert property (@(posedge clock) disable iff (!resetn)
        !ce |=> $stable(acc_q) && $stable(mixOut_q))
        else $error("State moved while clock enable was low.");

    for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chk
        AST_PIN_SOURCE: assert property (@(posedge clock) disable iff (!resetn) // RULE_08
            (ceRun_q >= 6'h04 && $past(selectSource)) |-> selPipe_q[c][0] == $past(hopPins[c], 3))
            else $error("Pin selection did not reach the select pipe.");

        AST_REG_SOURCE: assert property (@(posedge clock) disable iff (!resetn) // RULE_09
            (ceRun_q >= 6'h02 && !$past(selectSource)) |-> selPipe_q[c][0] == $past(regSel[c]))
            else $error("Register selection not used in register mode.");

        AST_HOP_LATENCY: assert property (@(posedge clock) disable iff (!resetn) // RULE_07
            (ceRun_q == 6'h3F) |-> selActive[c] == $past(selRaw[c], SEL_PIPE_DEPTH))
            else $error("Hop selection latency wrong.");

        AST_ADC_LATENCY: assert property (@(posedge clock) disable iff (!resetn) // RULE_07
            (ceRun_q == 6'h3F) |-> sampleLast[c] == $past(adcSample[c], SAMPLE_DLY))
            else $error("Sample latency to mixer wrong.");

        AST_MIX_ZERO: assert property (@(posedge clock) disable iff (!resetn) // RULE_20
            (ce && sampleLast[c] == '0) |=> mixOut_q[c] == '0)
            else $error("Mixer output not zero for zero sample.");

        for (genvar n = 0; n < NUM_NCO; n++) begin : g_nco
            localparam logic [ADDR_W-1:0] TW_ADDR = (c == 0 ? TW_A_OFS : TW_B_OFS)
                                                  + ADDR_W'(n * 4);

            AST_ACC_RUNS: assert property (@(posedge clock) disable iff (!resetn) // RULE_03
                (ce && !sysHit) |=> acc_q[c][n] == $past(acc_q[c][n]) + $past(tw_q[c][n]))
                else $error("Accumulator did not advance by its tuning word.");

            AST_TW_WRITE: assert property (@(posedge clock) disable iff (!resetn) // RULE_02
                (ce && wrHit && address == TW_ADDR && byteenable == 4'hF)
                |=> tw_q[c][n] == $past(writedata)
                    && tw_q[c][(n + 1) % NUM_NCO] == $past(tw_q[c][(n + 1) % NUM_NCO]))
                else $error("Tuning word write wrong or disturbed a neighbour.");
        end
    end

endmodule : ddc_nco_hop_select

/* hdl/ddc_nco_pkg.sv */
// Constants and types for the down-converter NCO bank with hop selection.
// Assumes one sample clock at 200 MHz; every clock carries one ADC sample.

package ddc_nco_pkg;

    // ------------------------------------------------------------------
    // Structure
    // ------------------------------------------------------------------
    localparam int NUM_CHAN  = 2;
    localparam int NUM_NCO   = 4;
    localparam int SEL_W     = 2;
    localparam int ACC_W     = 32;
    localparam int PHASE_W   = 16;
    localparam int RDIV_W    = 16;
    localparam int SAMPLE_W  = 12;
    localparam int LUT_W     = 12;
    localparam int LUT_IDX_W = 6;
    localparam int PROD_W    = 24;
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 32;
    localparam int BE_W      = 4;
    localparam int CTRL_W    = 5;
    localparam int RUN_W     = 6;

    // ------------------------------------------------------------------
    // Latencies in clock cycles
    // ------------------------------------------------------------------
    localparam int ADC_MIXER_CYC  = 37;
    localparam int HOP_MIXER_CYC  = 45;
    localparam int SYNC_STAGES    = 2;
    localparam int SAMPLE_DLY     = ADC_MIXER_CYC - 1;
    localparam int SEL_PIPE_DEPTH = HOP_MIXER_CYC - SYNC_STAGES - 1;

    // ------------------------------------------------------------------
    // Register map (byte addresses) and field positions
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] CTRL_OFS   = 8'h00;
    localparam logic [ADDR_W-1:0] RDIV_OFS   = 8'h04;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] TW_A_OFS   = 8'h10;
    localparam logic [ADDR_W-1:0] TW_B_OFS   = 8'h20;
    localparam logic [ADDR_W-1:0] PH_A_OFS   = 8'h30;
    localparam logic [ADDR_W-1:0] PH_B_OFS   = 8'h40;

    localparam int SRC_BIT    = 0;
    localparam int SELA_LSB   = 1;
    localparam int SELB_LSB   = 3;
    localparam int ARM_BIT    = 5;
    localparam int ACTA_LSB   = 0;
    localparam int ACTB_LSB   = 2;
    localparam int ARMED_BIT  = 4;
    localparam int DONE_BIT   = 5;
    localparam int BASIC_BIT  = 6;

    localparam logic [CTRL_W-1:0]  CTRL_RST = 5'h00;
    localparam logic [RDIV_W-1:0]  RDIV_RST = 16'h0000;
    localparam logic [ACC_W-1:0]   TW_RST   = 32'h0000_0000;
    localparam logic [PHASE_W-1:0] PH_RST   = 16'h0000;

    // Quarter-wave sine, amplitude 2047, 16 steps per quadrant plus the peak.
    localparam logic [16:0][LUT_W-1:0] SIN_QTR = {
        12'h7FF, 12'h7F5, 12'h7D8, 12'h7A7, 12'h763, 12'h70D, 12'h6A6, 12'h62E,
        12'h5A7, 12'h513, 12'h471, 12'h3C5, 12'h30F, 12'h252, 12'h18F, 12'h0C9,
        12'h000};

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef logic [SEL_W-1:0] sel_t;

    typedef struct packed {
        logic signed [PROD_W-1:0] i;
        logic signed [PROD_W-1:0] q;
    } iq_s;

    typedef enum logic [2:0] {
        AREA_NONE   = 3'h0,
        AREA_CTRL   = 3'h1,
        AREA_RDIV   = 3'h2,
        AREA_STATUS = 3'h3,
        AREA_TW     = 3'h4,
        AREA_PH     = 3'h5
    } area_e;

    typedef struct packed {
        area_e area;
        logic  chan;
        sel_t  idx;
    } decode_s;

endpackage : ddc_nco_pkg

/* bench/hop_pin_driver.sv */
// Partner model: the external logic that drives the hop-select pins.
// Assumes the bench hands it a wanted code per channel on the sample clock.
module hop_pin_driver
    import ddc_nco_pkg::*;
(
    // Clock
    input  wire logic             clock,
    // Wanted codes from the host side
    input  wire logic [SEL_W-1:0] wantA,
    input  wire logic [SEL_W-1:0] wantB,
    // Pins into the block
    output logic      [SEL_W-1:0] pinsA,
    output logic      [SEL_W-1:0] pinsB
);
    timeunit 1ns;
    timeprecision 1ps;

    // The pins change freely; no cycle-exact hop instant is assumed downstream.
    always_ff @(posedge clock) begin
        pinsA <= wantA;
        pinsB <= wantB;
    end
endmodule : hop_pin_driver

/* bench/testbench.sv */
// Self-checking bench for the NCO bank with hop selection.
// Assumes the design package and the hop pin partner model are compiled first.
module testbench;
    import ddc_nco_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic clock = 0, resetn = 0, read = 0, write = 0, sysref = 0, ce = 1;
    logic [ADDR_W-1:0] address = '0;
    logic [DATA_W-1:0] writedata = '0, rdata, readdata;
    logic waitrequest;
    logic [SEL_W-1:0] wantA = '0, wantB = '0, pinsA, pinsB;
    logic [NUM_CHAN-1:0][SAMPLE_W-1:0] adcSample = '0;
    iq_s [NUM_CHAN-1:0] mixOut;
    int err_total = 0, checks = 0;

    always #2.5 clock = ~clock;

    hop_pin_driver drv (.clock(clock), .wantA(wantA), .wantB(wantB), .pinsA(pinsA),
                        .pinsB(pinsB));
    ddc_nco_hop_select uut (.clock(clock), .resetn(resetn), .ce(ce), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(4'hF),
        .readdata(readdata), .waitrequest(waitrequest), .hopPinsChanA(pinsA),
        .hopPinsChanB(pinsB), .sysref(sysref), .adcSample(adcSample), .mixOut(mixOut));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic wrap_up;
        if (err_total == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // One request held until waitrequest is sampled low, then an idle edge.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        read <= !w;
        write <= w;
        address <= a;
        writedata <= d;
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        rdata = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (n >= 50) begin
            err_total++;
            wrap_up();
        end
        @(posedge clock);
    endtask : bus

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, '0);
        chk(rdata, exp);
    endtask : rd_chk

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic reset_values;
        rd_chk(CTRL_OFS, 32'h0000_0000);
        rd_chk(STATUS_OFS, 32'h0000_0040);
        rd_chk(8'h0C, 32'h0000_0000);
        rd_chk(8'h11, 32'h0000_0000);
    endtask : reset_values

    task automatic mixer_and_offsets;
        bus(1'b1, PH_A_OFS, 32'h0001_4000);
        bus(1'b1, TW_A_OFS + 8'h04, 32'hDEAD_BEEF);
        rd_chk(PH_A_OFS, 32'h0000_4000);
        rd_chk(TW_A_OFS + 8'h04, 32'hDEAD_BEEF);
        rd_chk(TW_A_OFS + 8'h08, 32'h0000_0000);
        rd_chk(PH_B_OFS, 32'h0000_0000);
        adcSample <= {12'sd100, 12'sd100};
        repeat (45) @(posedge clock);
        chk(mixOut[0].i, 32'sd0);
        chk(mixOut[0].q, -32'sd204700);
        chk(mixOut[1].i, 32'sd204700);
        chk(mixOut[1].q, 32'sd0);
    endtask : mixer_and_offsets

    task automatic sync_arm;
        bus(1'b1, CTRL_OFS, 32'h0000_0020);
        rd_chk(CTRL_OFS, 32'h0000_0020);
        sysref <= 1'b1;
        @(posedge clock);
        sysref <= 1'b0;
        @(posedge clock);
        rd_chk(STATUS_OFS, 32'h0000_0060);
        rd_chk(CTRL_OFS, 32'h0000_0000);
    endtask : sync_arm

    task automatic select_paths;
        wantA <= 2'b01;
        wantB <= 2'b01;
        bus(1'b1, CTRL_OFS, 32'h0000_001C);
        repeat (50) @(posedge clock);
        rd_chk(STATUS_OFS, 32'h0000_006E);
        wantB <= 2'b00;
        bus(1'b1, CTRL_OFS, 32'h0000_0001);
        repeat (50) @(posedge clock);
        rd_chk(STATUS_OFS, 32'h0000_0061);
        wantA <= 2'b11;
        wantB <= 2'b10;
        repeat (30) @(posedge clock);
        rd_chk(STATUS_OFS, 32'h0000_0061);
        repeat (30) @(posedge clock);
        rd_chk(STATUS_OFS, 32'h0000_006B);
        bus(1'b1, RDIV_OFS, 32'h0001_2345);
        rd_chk(RDIV_OFS, 32'h0000_2345);
        rd_chk(STATUS_OFS, 32'h0000_002B);
    endtask : select_paths

    // A running NCO on channel A must hold its output while the enable is low,
    // and a read presented meanwhile must wait until the enable returns.
    task automatic freeze_hold;
        logic [31:0] snapI;
        logic [31:0] snapQ;
        bus(1'b1, TW_A_OFS + 8'h0C, 32'h1000_0000);
        ce <= 1'b0;
        read <= 1'b1;
        address <= STATUS_OFS;
        @(posedge clock);
        snapI = mixOut[0].i;
        snapQ = mixOut[0].q;
        repeat (4) @(posedge clock);
        chk(mixOut[0].i, snapI);
        chk(mixOut[0].q, snapQ);
        chk(waitrequest, 32'h0000_0001);
        ce <= 1'b1;
        bus(1'b0, STATUS_OFS, '0);
        chk(rdata, 32'h0000_002B);
    endtask : freeze_hold

    initial begin
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        reset_values();
        mixer_and_offsets();
        sync_arm();
        select_paths();
        freeze_hold();
        wrap_up();
    end
endmodule : testbench
